// ===== core/wwd_core.sv
/*
  window watchdog: 7-bit free-running downcounter with window check,
  apb register slave, halt-mode handling and a timed reset pulse.
  assumes ref_clk doubles as the oscillator tick, all inputs are
  synchronous, and the surrounding reset circuit feeds ext_reset back
  as a one-cycle pulse for resets that are not the power-on rst_n.
*/
// Contract
// - decrement once every 16384 oscillator periods
// - timeout set in 64 steps by bits 5:0
// - expiry 40h to 3Fh pulls reset ~30 us; here not on the last step in plain halt
// - reload above window value forces a reset
// - software mode: off at reset, sticky once set
// - hardware mode: always active, enable bit ignored
// - counter runs even while watchdog disabled
// - control writes never clear the prescaler
// - enable set, top bit clear: immediate reset
// - active plus halt option: halt gives reset; here only with timebase irq off, else active halt
// - plain halt: one more step, then frozen
// - interrupt wake from halt: start-up delay first
// - reset ending halt returns disabled state
// - no irq enable, halt option: reset not halt
// - active halt freezes; interrupt resumes at once
// - reset ending active halt: start-up delay
// - bits 5:0 give steps left before reset
// - first step waits timebase-dependent minimum delay
// - control: enable bit 7, counter bits 6:0
// - control and window registers reset to 7Fh
// - window value bits 6:0, bit 7 reserved
`timescale 1ns/100ps
module wwd_core #(
  parameter int unsigned PRESCALE = wwd_pkg::PRESCALE_CYC,  // step period
  parameter int unsigned ADDR_W   = 8                       // apb address
) (
  input  wire logic              ref_clk,      // 100 MHz clock
  input  wire logic              rst_n,        // power-on reset, async
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb access phase
  input  wire logic              pwrite,       // apb direction
  input  wire logic [ADDR_W-1:0] paddr,        // apb byte address
  input  wire logic [31:0]       pwdata,       // apb write data
  output logic      [31:0]       prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // apb error, unmapped
  input  wire logic              halt_exec,    // halt instruction pulse
  input  wire logic              wake_irq,     // wake interrupt pulse
  input  wire logic              ext_reset,    // other mcu reset pulse
  output logic                   halt_allow,   // halt may be entered
  output logic                   wdg_reset_n,  // reset pin drive, low
  output logic                   wdg_active,   // watchdog can reset
  output logic                   cpu_halted    // some halt state held
);
  localparam logic [wwd_pkg::PRE_W-1:0] PRE_LAST =
    wwd_pkg::PRE_W'(PRESCALE - 1);
  localparam logic [wwd_pkg::DLY_W-1:0] RST_LAST =
    wwd_pkg::DLY_W'(wwd_pkg::RST_PULSE_CYC - 1);
  localparam logic [wwd_pkg::DLY_W-1:0] DLY_SHORT =
    wwd_pkg::DLY_W'(wwd_pkg::STARTUP_SHORT - 1);
  localparam logic [wwd_pkg::DLY_W-1:0] DLY_LONG =
    wwd_pkg::DLY_W'(wwd_pkg::STARTUP_LONG - 1);
  localparam logic [wwd_pkg::PRE_W-1:0] SINCE_MAX = '1;

  // whole block state in one record
  typedef struct packed {
    wwd_pkg::wwd_state_t            st;     // mode of the block
    logic                           act;    // activation_bit
    logic [6:0]                     cnt;    // downcounter
    logic [6:0]                     win;    // window_value
    logic [5:0]                     cfg;    // option settings
    logic [wwd_pkg::PRE_W-1:0]      pre;    // cycle prescaler
    logic [wwd_pkg::PRE_W-1:0]      since;  // cycles since last reload
    logic                           pend;   // step held for min delay
    logic [wwd_pkg::DLY_W-1:0]      tmr;    // pulse / start-up timer
    logic [31:0]                    rdat;   // captured read data
  } wwd_regs_t;

  wwd_regs_t q;  // registered state
  wwd_regs_t d;  // next state

  // minimum wait from a reload to the first step, per timebase
  function automatic logic [wwd_pkg::PRE_W-1:0] min_base(
    input logic [1:0] tb
  );
    int unsigned lsb;
    int unsigned v;
    unique case (tb)
      2'h0:    lsb = wwd_pkg::TB_LSB0;
      2'h1:    lsb = wwd_pkg::TB_LSB1;
      2'h2:    lsb = wwd_pkg::TB_LSB2;
      default: lsb = wwd_pkg::TB_LSB3;
    endcase
    v = (lsb + wwd_pkg::BASE_ADD) * wwd_pkg::BASE_MULT;
    // a shortened prescaler must not make the minimum unreachable
    if (v > PRESCALE - 1) begin
      v = PRESCALE - 1;
    end
    return wwd_pkg::PRE_W'(v);
  endfunction : min_base

  // true when the byte address hits one of the four registers
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(wwd_pkg::CTRL_OFF) ||
           a == ADDR_W'(wwd_pkg::WIN_OFF)  ||
           a == ADDR_W'(wwd_pkg::CFG_OFF)  ||
           a == ADDR_W'(wwd_pkg::STAT_OFF);
  endfunction : is_mapped

  logic       acc_wr;    // write completes this cycle
  logic       ctrl_wr;   // control register written
  logic       active;    // watchdog may produce a reset
  logic       counting;  // counter allowed to step
  logic       step_ok;   // minimum delay since reload has passed
  logic       dec;       // counter steps this cycle
  logic       fire;      // start a reset pulse this cycle
  logic       act_new;   // enable state after a control write

  // zero wait states: every access finishes in its first access cycle
  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~is_mapped(paddr);
  assign prdata      = q.rdat;
  assign wdg_reset_n = (q.st != wwd_pkg::ST_RST);
  assign wdg_active  = active;
  assign cpu_halted  = (q.st == wwd_pkg::ST_HONE) ||
                       (q.st == wwd_pkg::ST_HSTOP) ||
                       (q.st == wwd_pkg::ST_AHALT);
  // halt is refused only when it would turn into a reset
  assign halt_allow  = ~(active & q.cfg[wwd_pkg::CFG_HALT_RST] &
                         ~q.cfg[wwd_pkg::CFG_TB_IRQ]);

  assign acc_wr  = psel & penable & pwrite;
  assign ctrl_wr = acc_wr & (paddr == ADDR_W'(wwd_pkg::CTRL_OFF));
  assign active  = q.cfg[wwd_pkg::CFG_HW] | q.act;
  assign act_new = q.act | pwdata[wwd_pkg::ACT_BIT];
  // slow and wait only slow the cpu; this clock never changes rate
  assign counting = (q.st == wwd_pkg::ST_RUN) ||
                    (q.st == wwd_pkg::ST_HONE);
  assign step_ok  = q.since >=
                    min_base(q.cfg[wwd_pkg::CFG_TB_LO +: 2]);
  // a wrap before the minimum delay is held until it has elapsed
  assign dec = counting & step_ok &
               ((q.pre == PRE_LAST) | q.pend);

  // reset causes, gated on the activation state; the top-bit reset on act_new, the enable state after the write
  always_comb begin
    fire = 1'b0;
    if (counting && dec && active && q.cnt == wwd_pkg::TOP_EDGE &&
        q.st == wwd_pkg::ST_RUN) begin
      fire = 1'b1;
    end
    if (ctrl_wr && q.st == wwd_pkg::ST_RUN) begin
      // reload strictly above the window is early; equal is fine
      if (active && q.cnt > q.win) begin
        fire = 1'b1;
      end
      if ((q.cfg[wwd_pkg::CFG_HW] | act_new) &&
          !pwdata[wwd_pkg::TOP_BIT]) begin
        fire = 1'b1;
      end
    end
    if (halt_exec && q.st == wwd_pkg::ST_RUN && active &&
        q.cfg[wwd_pkg::CFG_HALT_RST] &&
        !q.cfg[wwd_pkg::CFG_TB_IRQ]) begin
      fire = 1'b1;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    d = q;
    // prescaler is free-running and never touched by writes
    d.pre = (q.pre == PRE_LAST) ? '0
                                : wwd_pkg::PRE_W'(q.pre + 1'b1);
    if (q.since != SINCE_MAX) begin
      d.since = wwd_pkg::PRE_W'(q.since + 1'b1);
    end
    d.pend = counting & ~step_ok & ((q.pre == PRE_LAST) | q.pend);
    // the counter steps whether or not the watchdog is enabled
    if (dec) begin
      d.cnt = 7'(q.cnt - 1'b1);
      if (q.st == wwd_pkg::ST_HONE) begin
        d.st = wwd_pkg::ST_HSTOP;
      end
    end
    // read data is captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      unique case (1'b1)
        paddr == ADDR_W'(wwd_pkg::CTRL_OFF):
          d.rdat = {24'h000000, q.act, q.cnt};
        paddr == ADDR_W'(wwd_pkg::WIN_OFF):
          d.rdat = {25'h0, q.win};
        paddr == ADDR_W'(wwd_pkg::CFG_OFF):
          d.rdat = {26'h0, q.cfg};
        paddr == ADDR_W'(wwd_pkg::STAT_OFF):
          d.rdat = {26'h0, q.st};
        default:
          d.rdat = 32'h00000000;
      endcase
    end
    // register writes
    if (acc_wr && q.st == wwd_pkg::ST_RUN) begin
      if (paddr == ADDR_W'(wwd_pkg::CTRL_OFF)) begin
        d.act   = act_new;
        d.cnt   = pwdata[6:0];
        d.since = '0;
        d.pend  = 1'b0;
      end else if (paddr == ADDR_W'(wwd_pkg::WIN_OFF)) begin
        d.win = pwdata[6:0];
      end else if (paddr == ADDR_W'(wwd_pkg::CFG_OFF)) begin
        d.cfg = pwdata[5:0];
      end
    end
    // mode sequencing
    unique case (q.st)
      wwd_pkg::ST_RUN: begin
        if (halt_exec && !fire) begin
          if (q.cfg[wwd_pkg::CFG_TB_IRQ]) begin
            d.st = wwd_pkg::ST_AHALT;
          end else begin
            d.st = wwd_pkg::ST_HONE;
          end
        end
      end
      wwd_pkg::ST_HONE, wwd_pkg::ST_HSTOP: begin
        if (wake_irq) begin
          d.st  = wwd_pkg::ST_DLY;
          d.tmr = q.cfg[wwd_pkg::CFG_LONG] ? DLY_LONG : DLY_SHORT;
        end
      end
      wwd_pkg::ST_AHALT: begin
        if (wake_irq) begin
          d.st = wwd_pkg::ST_RUN;
        end
      end
      wwd_pkg::ST_DLY: begin
        if (q.tmr == '0) begin
          d.st = wwd_pkg::ST_RUN;
        end else begin
          d.tmr = wwd_pkg::DLY_W'(q.tmr - 1'b1);
        end
      end
      wwd_pkg::ST_RST: begin
        if (q.tmr != '0) begin
          d.tmr = wwd_pkg::DLY_W'(q.tmr - 1'b1);
        end
      end
      default: begin
        d.st = wwd_pkg::ST_RUN;  // illegal code recovers to counting
      end
    endcase
    // a watchdog reset starts the timed low pulse on the pin
    if (fire) begin
      d.st  = wwd_pkg::ST_RST;
      d.tmr = RST_LAST;
    end
    // end of pulse or a foreign reset: control and window back to reset values, options kept
    if ((q.st == wwd_pkg::ST_RST && q.tmr == '0) || ext_reset) begin
      d.act   = 1'b0;
      d.cnt   = wwd_pkg::CNT_RST;
      d.win   = wwd_pkg::WIN_RST;
      d.since = '0;
      d.pend  = 1'b0;
      d.st    = wwd_pkg::ST_RUN;
      if (ext_reset && q.st == wwd_pkg::ST_AHALT) begin
        d.st  = wwd_pkg::ST_DLY;
        d.tmr = q.cfg[wwd_pkg::CFG_LONG] ? DLY_LONG : DLY_SHORT;
      end
    end
  end

  // state register; options survive watchdog resets, not power-on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.st    <= wwd_pkg::ST_RUN;
      q.act   <= 1'b0;
      q.cnt   <= wwd_pkg::CNT_RST;
      q.win   <= wwd_pkg::WIN_RST;
      q.cfg   <= wwd_pkg::CFG_RST;
      q.pre   <= '0;
      q.since <= '0;
      q.pend  <= 1'b0;
      q.tmr   <= '0;
      q.rdat  <= 32'h00000000;
    end else begin
      q <= d;
    end
  end

  // helper: length of the current low phase of the reset pin
  logic [wwd_pkg::DLY_W:0] low_len;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_len <= '0;
    end else if (!wdg_reset_n) begin
      low_len <= (wwd_pkg::DLY_W + 1)'(low_len + 1'b1);
    end else begin
      low_len <= '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence ctrl_write_s;
    psel && penable && pwrite &&
    paddr == ADDR_W'(wwd_pkg::CTRL_OFF) && q.st == wwd_pkg::ST_RUN;
  endsequence
  sequence plain_halt_s;
    halt_exec && q.st == wwd_pkg::ST_RUN && !fire && !ext_reset &&
    !q.cfg[wwd_pkg::CFG_TB_IRQ];
  endsequence

  a_top_expiry: assert property (
    (dec && active && q.cnt == 7'h40 && q.st == wwd_pkg::ST_RUN &&
     !ext_reset) |=> !wdg_reset_n)
    else $error("expiry at 40h did not start reset");
  a_pulse_len: assert property (
    $rose(wdg_reset_n) |-> low_len == wwd_pkg::RST_PULSE_CYC)
    else $error("reset pulse length wrong");
  a_early_reload: assert property (
    (ctrl_write_s and (active && q.cnt > q.win && !ext_reset))
      |=> !wdg_reset_n)
    else $error("early reload did not reset");
  a_equal_reload: assert property (
    (ctrl_write_s and (q.cnt == q.win && pwdata[wwd_pkg::TOP_BIT] &&
      !dec && !halt_exec && !ext_reset)) |=> wdg_reset_n)
    else $error("reload at window value reset");
  a_enable_sticky: assert property (
    (q.act && q.st != wwd_pkg::ST_RST && !ext_reset) |=> q.act)
    else $error("enable bit cleared without reset");
  a_free_count: assert property (
    (dec && !active && !ctrl_wr && !ext_reset)
      |=> q.cnt == 7'($past(q.cnt) - 1'b1))
    else $error("disabled counter did not step");
  a_soft_reset: assert property (
    (ctrl_write_s and (pwdata[7] && !pwdata[6] && !ext_reset))
      |=> !wdg_reset_n)
    else $error("software reset not produced");
  a_halt_reset: assert property (
    (halt_exec && q.st == wwd_pkg::ST_RUN && active &&
     q.cfg[1] && !q.cfg[2] && !ext_reset) |=> q.st == wwd_pkg::ST_RST)
    else $error("halt with reset option did not reset");
  a_plain_halt: assert property (
    plain_halt_s |=> q.st == wwd_pkg::ST_HONE)
    else $error("plain halt not entered");
  a_ahalt_freeze: assert property (
    (q.st == wwd_pkg::ST_AHALT && !ext_reset) |=> $stable(q.cnt))
    else $error("counter moved in active halt");
  a_win_reserved: assert property (
    (psel && !penable && !pwrite && paddr == ADDR_W'(wwd_pkg::WIN_OFF))
      |=> prdata[31:7] == '0)
    else $error("window bit 7 not zero");

  // halt, wake and foreign-reset paths; a foreign reset always wins
  a_halt_step: assert property (
    (q.st == wwd_pkg::ST_HONE && dec && !wake_irq && !ext_reset)
      |=> q.st == wwd_pkg::ST_HSTOP && q.cnt == 7'($past(q.cnt) - 1'b1))
    else $error("plain halt did not take its last step");
  a_halt_freeze: assert property (
    (q.st == wwd_pkg::ST_HSTOP && !ext_reset) |=> $stable(q.cnt))
    else $error("counter moved in plain halt");
  a_wake_delay: assert property (
    (cpu_halted && q.st != wwd_pkg::ST_AHALT && wake_irq && !ext_reset)
      |=> q.st == wwd_pkg::ST_DLY)
    else $error("wake from plain halt skipped the delay");
  a_ahalt_wake: assert property (
    (q.st == wwd_pkg::ST_AHALT && wake_irq && !ext_reset)
      |=> q.st == wwd_pkg::ST_RUN)
    else $error("active halt did not resume at once");
  a_ext_clear: assert property (
    ext_reset |=> !q.act && q.cnt == wwd_pkg::CNT_RST)
    else $error("foreign reset left the watchdog enabled");
endmodule : wwd_core

// ===== core/wwd_pkg.sv
/*
  constants, field layout and state encoding of the window watchdog.
  assumes a 100 MHz ref_clk that also stands for the divided oscillator.
*/
package wwd_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFF      = 8'h00;  // control: enable + count
  localparam logic [7:0] WIN_OFF       = 8'h04;  // window limit
  localparam logic [7:0] CFG_OFF       = 8'h08;  // option settings
  localparam logic [7:0] STAT_OFF      = 8'h0C;  // block state, read only
  // reset values
  localparam logic [6:0] CNT_RST       = 7'h7F;
  localparam logic [6:0] WIN_RST       = 7'h7F;
  localparam logic [5:0] CFG_RST       = 6'h00;
  // control register fields
  localparam int         ACT_BIT       = 7;      // activation_bit
  localparam int         TOP_BIT       = 6;      // counter_top_bit
  localparam logic [6:0] TOP_EDGE      = 7'h40;  // last value before expiry
  // option register fields
  localparam int         CFG_HW        = 0;      // hardware activation
  localparam int         CFG_HALT_RST  = 1;      // halt_reset_option
  localparam int         CFG_TB_IRQ    = 2;      // timebase_irq_enable
  localparam int         CFG_TB_LO     = 3;      // timebase_select lsb
  localparam int         CFG_LONG      = 5;      // 4096-clock start-up
  // timing
  localparam int         PRESCALE_CYC  = 16384;  // osc periods per step
  localparam int         PRE_W         = 14;
  localparam int         DLY_W         = 13;
  localparam int         STARTUP_SHORT = 256;    // cpu clocks
  localparam int         STARTUP_LONG  = 4096;   // cpu clocks
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         RST_PULSE_NS  = 30000;  // reset pin low time
  localparam int         RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;
  // minimum base delay = (lsb + BASE_ADD) * BASE_MULT osc periods
  localparam int         BASE_ADD      = 128;
  localparam int         BASE_MULT     = 64;
  localparam int         TB_LSB0       = 59;
  localparam int         TB_LSB1       = 53;
  localparam int         TB_LSB2       = 35;
  localparam int         TB_LSB3       = 54;

  // block states, one-hot
  typedef enum logic [5:0] {
    ST_RUN   = 6'b000001,  // normal counting
    ST_HONE  = 6'b000010,  // plain halt, one step still to come
    ST_HSTOP = 6'b000100,  // plain halt, frozen and harmless
    ST_AHALT = 6'b001000,  // active halt, frozen
    ST_DLY   = 6'b010000,  // start-up delay before counting
    ST_RST   = 6'b100000   // driving the reset pin low
  } wwd_state_t;
endpackage : wwd_pkg

// ===== test/test_window_watchdog.sv
/*
  self-checking bench for the window watchdog core over apb.
  assumes a short prescale of 256 so steps come every 256 cycles.
*/
`timescale 1ns/100ps
module test_window_watchdog;
  typedef struct packed {
    logic [7:0]  addr;  // register offset
    logic [31:0] wd;    // value written
    logic [31:0] exp;   // value read back
    logic        err;   // slave error expected
  } wwd_row_t;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        halt_exec, wake_irq, ext_reset, fire, e;
  logic        halt_allow, wdg_reset_n, wdg_active, cpu_halted;
  logic [15:0] low_len_q;
  int          fails, n_compared, cyc;
  wwd_row_t    rows [7];

  wwd_core #(.PRESCALE(256), .ADDR_W(8)) wwd_core_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
    .wake_irq(wake_irq), .ext_reset(ext_reset), .halt_allow(halt_allow),
    .wdg_reset_n(wdg_reset_n), .wdg_active(wdg_active),
    .cpu_halted(cpu_halted));
  wwd_rst_model wwd_rst_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .wdg_reset_n(wdg_reset_n),
    .fire(fire), .ext_reset(ext_reset), .low_len_q(low_len_q));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);  // outputs launched by the access have settled
  endtask : apb

  // one-cycle pulse on a sideband input
  task automatic pulse(input int which);
    @(posedge ref_clk);
    if (which == 0) halt_exec <= 1'b1;
    else if (which == 1) wake_irq <= 1'b1;
    else fire <= 1'b1;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
    wake_irq  <= 1'b0;
    fire      <= 1'b0;
    @(posedge ref_clk);  // state launched by the pulse has settled
  endtask : pulse

  // wait for a watchdog reset pulse and check its length and aftermath
  task automatic reset_seen(input int lim);
    int n;
    n = 0;
    while (wdg_reset_n !== 1'b0 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk("reset pulse started", 1, n < lim);
    n = 0;
    while (wdg_reset_n !== 1'b1 && n < 3100) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    chk("pulse cycles", wwd_pkg::RST_PULSE_CYC, low_len_q);
    apb(wwd_pkg::CTRL_OFF, 1'b0, 32'h0);
    chk("control after reset", 32'h7F, r);
  endtask : reset_seen

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // hang guard: whole run is well under this many cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      results();
    end
  end

  initial begin
    {psel, penable, pwrite, halt_exec, wake_irq, fire} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    // window bit 7 reserved; unmapped offset refused; status read only
    rows = '{'{8'h04, 32'h55, 32'h55, 1'b0}, '{8'h04, 32'hFF, 32'h7F, 1'b0},
      '{8'h04, 32'h7F, 32'h7F, 1'b0}, '{8'h00, 32'h45, 32'h45, 1'b0},
      '{8'h00, 32'h7F, 32'h7F, 1'b0}, '{8'h10, 32'h12, 32'h00, 1'b1},
      '{8'h0C, 32'h3F, 32'h01, 1'b0}};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].addr, 1'b1, rows[i].wd);
      apb(rows[i].addr, 1'b0, 32'h0);
      chk("row read", rows[i].exp, r);
      chk("row error", rows[i].err, e);
    end
    $display("test register rows done");
    // free-running count while disabled, no prescaler clear
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'h7F);
    repeat (800) @(posedge ref_clk);
    apb(wwd_pkg::CTRL_OFF, 1'b0, 32'h0);
    chk("count 7C-7D", 1, r == 32'h7C || r == 32'h7D);
    $display("test free count done");
    // enable is sticky; reload equal to window is allowed
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hFF);
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'h7F);
    chk("active", 1, wdg_active);
    chk("no reset", 1, wdg_reset_n);
    apb(wwd_pkg::CTRL_OFF, 1'b0, 32'h0);
    chk("enable kept", 32'hFF, r);
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'h80);  // deliberate soft reset
    reset_seen(10);
    chk("inactive", 0, wdg_active);
    $display("test enable and soft reset done");
    // reload above the window
    apb(wwd_pkg::WIN_OFF, 1'b1, 32'h50);
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hFF);
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hFF);
    reset_seen(10);
    // expiry from 41h: two steps to 3Fh
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hC1);
    reset_seen(800);
    $display("test window and expiry done");
    // hardware activation
    apb(wwd_pkg::CFG_OFF, 1'b1, 32'h01);
    chk("hw active", 1, wdg_active);
    apb(wwd_pkg::CFG_OFF, 1'b1, 32'h02);
    chk("sw off", 0, wdg_active);
    // halt with reset option
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hFF);
    chk("halt blocked", 0, halt_allow);
    pulse(0);
    reset_seen(10);
    $display("test hw and halt reset done");
    // active halt: freeze, wake at once, reset gives start-up delay
    apb(wwd_pkg::CFG_OFF, 1'b1, 32'h24);  // active halt, 4096 start-up
    pulse(0);
    chk("active halt", 1, cpu_halted);
    pulse(1);
    chk("woken", 0, cpu_halted);
    pulse(0);
    pulse(2);
    apb(wwd_pkg::STAT_OFF, 1'b0, 32'h0);
    chk("delay state", 32'h10, r);
    repeat (260) @(posedge ref_clk);
    apb(wwd_pkg::STAT_OFF, 1'b0, 32'h0);
    chk("long delay", 32'h10, r);
    repeat (3840) @(posedge ref_clk);
    apb(wwd_pkg::STAT_OFF, 1'b0, 32'h0);
    chk("running", 32'h01, r);
    // plain halt: one step then frozen; wake after start-up delay
    apb(wwd_pkg::CFG_OFF, 1'b1, 32'h00);
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'h7F);
    pulse(0);
    repeat (600) @(posedge ref_clk);
    apb(wwd_pkg::STAT_OFF, 1'b0, 32'h0);
    chk("halt stopped", 32'h04, r);
    apb(wwd_pkg::CTRL_OFF, 1'b0, 32'h0);
    chk("one step", 32'h7E, r);
    pulse(1);
    apb(wwd_pkg::STAT_OFF, 1'b0, 32'h0);
    chk("wake delay", 32'h10, r);
    repeat (260) @(posedge ref_clk);
    apb(wwd_pkg::STAT_OFF, 1'b0, 32'h0);
    chk("resumed", 32'h01, r);
    // a foreign reset ends plain halt with the watchdog disabled
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hFF);
    pulse(0);
    pulse(2);
    apb(wwd_pkg::CTRL_OFF, 1'b0, 32'h0);
    chk("halt reset state", 32'h7F, r);
    $display("test halt modes done");
    // power-on reset values; move them away first so the checks bite
    apb(wwd_pkg::WIN_OFF, 1'b1, 32'h33);
    apb(wwd_pkg::CTRL_OFF, 1'b1, 32'hFF);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(wwd_pkg::CTRL_OFF, 1'b0, 32'h0);
    chk("control reset", 32'h7F, r);
    apb(wwd_pkg::WIN_OFF, 1'b0, 32'h0);
    chk("window reset", 32'h7F, r);
    chk("pin idle", 1, wdg_reset_n);
    chk("enable reset", 0, wdg_active);
    $display("test reset values done");
    results();
  end
endmodule : test_window_watchdog

// ===== test/wwd_rst_model.sv
/*
  model of the mcu reset circuit beside the watchdog: times each low
  pulse on the watchdog reset pin and sends other resets as pulses.
  assumes a single clock and a synchronous fire request from the bench.
*/
`timescale 1ns/100ps
module wwd_rst_model (
  input  wire logic        ref_clk,      // system clock
  input  wire logic        rst_n,        // power-on reset, low
  input  wire logic        wdg_reset_n,  // watchdog reset pin, low
  input  wire logic        fire,         // bench asks for another reset
  output logic             ext_reset,    // one-cycle reset pulse
  output logic [15:0]      low_len_q     // length of last low pulse
);
  logic [15:0] cnt_q;  // cycles seen low so far

  // pulse length is latched when the pin rises again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 16'h0000;
      low_len_q <= 16'h0000;
      ext_reset <= 1'b0;
    end else begin
      ext_reset <= fire;  // other reset source, one cycle
      if (!wdg_reset_n) begin
        cnt_q <= cnt_q + 16'h0001;  // pin held low
      end else if (cnt_q != 16'h0000) begin
        low_len_q <= cnt_q;
        cnt_q     <= 16'h0000;
      end
    end
  end
endmodule : wwd_rst_model
